// *** hdl/vtr_pkg.sv ***
// Behaviour
// RULE1: Reset loads program counter with reset vector
// RULE2: Enabled external edge vectors when stack free
// RULE3: External edge selectable: falling, rising, both
// RULE4: Enabled timer overflow vectors when stack free
// RULE5: Enabled conversion complete vectors when stack free
// RULE6: Table pointer supplies table low address bits
// RULE7: Table read low byte to m, high separately
// RULE8: Unbacked table_high_byte bits read zero
// RULE9: Current page read uses pc_upper_bits
// RULE10: Last page read forces upper bits to one
// RULE11: Table read takes two cycles
// RULE12: table_high_byte ignores software writes
// RULE13: Byte wide data memory from 00H, SFRs first
// RULE14: General purpose bytes readable and writable
// RULE15: Bit set/clear on any unprotected bit
// RULE16: Indirect access through memory pointer
// RULE17: Some SFRs are read-only
// RULE18: Unused special addresses read 00H
// RULE19: Reserved gap before general area reads 00H
// RULE20: Program memory is 1024 words of 14 bits
// RULE21: Two level stack; full stack defers interrupts
// RULE22: Distinct fixed vectors, fixed priority
`default_nettype none
package vtr_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned PC_W      = 10;
  localparam int unsigned PW_W      = 14;
  localparam int unsigned PM_DEPTH  = 1024;
  localparam int unsigned GP_DEPTH  = 32;
  localparam int unsigned STK_DEPTH = 2;
  localparam logic [1:0]  STK_FULL  = 2'h2;
  // ==========================================================
  // Vectors, ext highest priority
  localparam logic [9:0]  RST_VEC   = 10'h000;
  localparam logic [9:0]  EXT_VEC   = 10'h004;
  localparam logic [9:0]  TMR_VEC   = 10'h008;
  localparam logic [9:0]  ADC_VEC   = 10'h00C;
  localparam logic [1:0]  LAST_PAGE = 2'h3;
  localparam int unsigned P_EXT     = 0;
  localparam int unsigned P_TMR     = 1;
  localparam int unsigned P_ADC     = 2;
  // ==========================================================
  // Bus map (byte offsets, haddr[11:0])
  localparam logic [11:0] OFS_CMD   = 12'h000;
  localparam logic [11:0] OFS_PC    = 12'h004;
  localparam logic [11:0] OFS_PMA   = 12'h008;
  localparam logic [11:0] OFS_PMD   = 12'h00C;
  localparam logic [1:0]  DM_WIN    = 2'h1;
  // Command word fields
  localparam int unsigned CMD_OP_LSB  = 16;
  localparam int unsigned CMD_BIT_LSB = 8;
  localparam logic [2:0]  OP_NONE   = 3'h0;
  localparam logic [2:0]  OP_TABLE_READ_CURRENT_PAGE = 3'h1;
  localparam logic [2:0]  OP_TABRDL = 3'h2;
  localparam logic [2:0]  OP_RET    = 3'h3;
  localparam logic [2:0]  OP_BSET   = 3'h4;
  localparam logic [2:0]  OP_BCLR   = 3'h5;
  localparam logic [2:0]  OP_STEP   = 3'h6;
  // ==========================================================
  // Data memory map
  localparam logic [7:0]  A_IAR0    = 8'h00;
  localparam logic [7:0]  A_MP0     = 8'h01;
  localparam logic [7:0]  A_PCL     = 8'h06;
  localparam logic [7:0]  A_TBLP    = 8'h07;
  localparam logic [7:0]  A_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0]  A_SEQ     = 8'h09;
  localparam logic [7:0]  A_SYSTEM_CONTROL_REG_1 = 8'h0C;
  localparam logic [2:0]  GP_PAGE   = 3'h1;
  localparam logic [7:0]  GP_END    = 8'h40;
  // system_control_reg_1 fields
  localparam int unsigned C_EDGE_LSB = 0;
  localparam int unsigned C_EXT_EN   = 2;
  localparam int unsigned C_TMR_EN   = 3;
  localparam int unsigned C_ADC_EN   = 4;
  localparam logic [7:0]  CONTROL_RST  = 8'h00;
  localparam logic [7:0]  CONTROL_MASK = 8'h1F;
  localparam logic [1:0]  EDGE_FALL  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_WRITE} vtr_st_t;
endpackage
`default_nettype wire

// *** hdl/vtr_top.sv ***
// Chosen here: register access over AHB-Lite and the register offsets.
`default_nettype none
module vtr_top (
  // Clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_n,
  // AHB-Lite slave
  input  wire logic                          i_hsel,
  input  wire logic [31:0]                   i_haddr,
  input  wire logic [1:0]                    i_htrans,
  input  wire logic                          i_hwrite,
  input  wire logic [2:0]                    i_hsize,
  input  wire logic [31:0]                   i_hwdata,
  input  wire logic                          i_hready,
  output logic      [31:0]                   o_hrdata,
  output logic                               o_hreadyout,
  output logic                               o_hresp,
  // Event sources
  input  wire logic                          i_ext_int,
  input  wire logic                          i_tmr_ovf,
  input  wire logic                          i_adc_done,
  // Sequencer view
  output logic      [vtr_pkg::PC_W-1:0]      o_pc
);
  import vtr_pkg::*;

  // ==========================================================
  // Storage
  logic [PW_W-1:0] pm_mem [PM_DEPTH];  // RULE20
  logic [7:0]      gp_mem [GP_DEPTH];
  logic [PC_W-1:0] stk_r  [STK_DEPTH];
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pma_r;
  logic [PC_W-1:0] tab_addr;
  logic [PC_W-1:0] vec_sel;
  logic [1:0]      sp_r;
  logic [1:0]      sp_dec;
  logic [7:0]      mp0_r;
  logic [7:0]      tblp_r;
  logic [7:0]      table_high_byte_r;
  logic [7:0]      system_control_reg_1_r;
  logic [2:0]      pend_r;
  logic [2:0]      ev;
  logic [2:0]      ack_vec;
  logic            ext_q_r;
  logic            ext_edge;
  logic            ack_ok;
  vtr_st_t         st_r;
  logic [2:0]      op_r;
  logic [7:0]      m_r;
  logic [PW_W-1:0] tw_r;
  logic [5:0]      tw_hi;
  // Bus side
  logic            ph_r;
  logic            wr_r;
  logic [11:0]     a_r;
  logic [31:0]     hrdata_r;
  logic            hready_r;
  logic            hresp_r;
  logic [31:0]     rd_mux;
  logic            take;
  logic            done;
  logic            hw;
  logic            dm_hit;
  logic [7:0]      a_dm;
  logic            cmd_go;
  logic [2:0]      cmd_op;
  logic [2:0]      cmd_bit;
  logic [7:0]      cmd_m;
  logic [7:0]      bit_sel;
  logic [7:0]      bit_cur;
  // Data memory write port
  logic            wr_en;
  logic [7:0]      wr_a;
  logic [7:0]      wr_d;

  // ==========================================================
  // Address helpers
  // Pointer slot redirects to the address held in the pointer
  function automatic logic [7:0] eff_a(input logic [7:0] a);
    eff_a = (a == A_IAR0) ? mp0_r : a;  // RULE16
  endfunction

  // Data memory read; anything not backed reads zero
  function automatic logic [7:0] dm_rd(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;  // RULE18
    case (a)
      A_MP0:   d = mp0_r;
      A_PCL:   d = pc_r[7:0];
      A_TBLP:  d = tblp_r;
      A_TABLE_HIGH_BYTE:      d = table_high_byte_r;
      A_SEQ:                  d = {3'h0, pend_r, sp_r};
      A_SYSTEM_CONTROL_REG_1: d = system_control_reg_1_r;
      default: begin
        if (a[7:5] == GP_PAGE) begin
          d = gp_mem[a[4:0]];  // RULE13
        end
      end
    endcase
    dm_rd = d;  // RULE19
  endfunction

  // ==========================================================
  // Bus decode
  assign take    = i_hsel & i_htrans[1] & i_hready;
  // Data phase waits while a table read owns the write port
  assign done    = ph_r & (st_r == S_IDLE);
  assign hw      = done & wr_r;
  assign dm_hit  = (a_r[11:10] == DM_WIN);
  assign a_dm    = a_r[9:2];
  assign cmd_go  = hw & (a_r == OFS_CMD);
  assign cmd_op  = i_hwdata[CMD_OP_LSB +: 3];
  assign cmd_bit = i_hwdata[CMD_BIT_LSB +: 3];
  assign cmd_m   = i_hwdata[7:0];

  // Read data for the current data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dm_hit) begin
      rd_mux[7:0] = dm_rd(eff_a(a_dm));
    end else begin
      case (a_r)
        OFS_CMD: rd_mux[4:0] = {pend_r, sp_r};
        OFS_PC:  rd_mux[PC_W-1:0] = pc_r;
        OFS_PMA: rd_mux[PC_W-1:0] = pma_r;
        OFS_PMD: rd_mux[PW_W-1:0] = pm_mem[pma_r];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Every transfer takes at least one wait state, more while a table read runs; keeps reads coherent
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ph_r     <= 1'b0;
      wr_r     <= 1'b0;
      a_r      <= 12'h000;
      hready_r <= 1'b1;
      hrdata_r <= 32'h0000_0000;
      hresp_r  <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      if (take) begin
        ph_r     <= 1'b1;
        wr_r     <= i_hwrite;
        a_r      <= i_haddr[11:0];
        hready_r <= 1'b0;
      end else if (done) begin
        ph_r     <= 1'b0;
        hready_r <= 1'b1;
        if (!wr_r) begin
          hrdata_r <= rd_mux;
        end
      end
    end
  end

  assign o_hrdata    = hrdata_r;
  assign o_hreadyout = hready_r;
  assign o_hresp     = hresp_r;
  assign o_pc        = pc_r;

  // ==========================================================
  // Data memory write port, table read first
  always_comb begin
    wr_en   = 1'b0;
    wr_a    = 8'h00;
    wr_d    = 8'h00;
    bit_sel = 8'h01 << cmd_bit;
    bit_cur = dm_rd(eff_a(cmd_m));
    if (st_r == S_WRITE) begin
      wr_en = 1'b1;
      wr_a  = eff_a(m_r);
      wr_d  = tw_r[7:0];  // RULE7
    end else if (hw & dm_hit) begin
      wr_en = 1'b1;
      wr_a  = eff_a(a_dm);
      wr_d  = i_hwdata[7:0];
    end else if (cmd_go & ((cmd_op == OP_BSET) | (cmd_op == OP_BCLR))) begin
      // Read-modify-write; protected bits drop it at storage
      wr_en = 1'b1;
      wr_a  = eff_a(cmd_m);
      wr_d  = (cmd_op == OP_BSET) ? (bit_cur | bit_sel) : (bit_cur & ~bit_sel);  // RULE15
    end
  end

  // Pointer register
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mp0_r <= 8'h00;
    end else if (wr_en & (wr_a == A_MP0)) begin
      mp0_r <= wr_d;
    end
  end

  // Table pointer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tblp_r <= 8'h00;
    end else if (wr_en & (wr_a == A_TBLP)) begin
      tblp_r <= wr_d;
    end
  end

  // Control register; unimplemented bits stay zero
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      system_control_reg_1_r <= CONTROL_RST;
    end else if (wr_en & (wr_a == A_SYSTEM_CONTROL_REG_1)) begin
      system_control_reg_1_r <= wr_d & CONTROL_MASK;
    end
  end

  // General purpose bytes; no reset, like RAM
  always_ff @(posedge i_mclk) begin
    if (wr_en & (wr_a[7:5] == GP_PAGE)) begin
      gp_mem[wr_a[4:0]] <= wr_d;  // RULE14
    end
  end

  // Table high byte: only the table read loads it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      table_high_byte_r <= 8'h00;
    end else if (st_r == S_WRITE) begin
      table_high_byte_r <= {2'h0, tw_hi};  // RULE8
    end
  end
  // Status and table high have no software write path
  assign tw_hi = tw_r[PW_W-1:8];  // RULE17 RULE12

  // ==========================================================
  // Program memory load port
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pma_r <= 10'h000;
    end else if (hw & (a_r == OFS_PMA)) begin
      pma_r <= i_hwdata[PC_W-1:0];
    end else if (hw & (a_r == OFS_PMD)) begin
      pma_r <= pma_r + 10'h001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (hw & (a_r == OFS_PMD)) begin
      pm_mem[pma_r] <= i_hwdata[PW_W-1:0];
    end
  end

  // ==========================================================
  // Table read sequencer
  assign tab_addr = {(op_r == OP_TABRDL) ? LAST_PAGE : pc_r[9:8], tblp_r};  // RULE6 RULE9 RULE10

  // Fetch then write: two cycles per table read
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r <= S_IDLE;
      op_r <= OP_NONE;
      m_r  <= 8'h00;
      tw_r <= 14'h0000;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (cmd_go & ((cmd_op == OP_TABLE_READ_CURRENT_PAGE) | (cmd_op == OP_TABRDL))) begin
            st_r <= S_FETCH;
            op_r <= cmd_op;
            m_r  <= cmd_m;
          end
        end
        S_FETCH: begin
          tw_r <= pm_mem[tab_addr];
          st_r <= S_WRITE;  // RULE11
        end
        S_WRITE: st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Vector events
  always_comb begin
    case (system_control_reg_1_r[C_EDGE_LSB +: 2])
      EDGE_FALL: ext_edge = ext_q_r & ~i_ext_int;
      EDGE_RISE: ext_edge = ~ext_q_r & i_ext_int;
      default:   ext_edge = ext_q_r ^ i_ext_int;  // RULE3
    endcase
  end

  assign ev = {i_adc_done & system_control_reg_1_r[C_ADC_EN],
               i_tmr_ovf & system_control_reg_1_r[C_TMR_EN],
               ext_edge & system_control_reg_1_r[C_EXT_EN]};

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ext_q_r <= 1'b0;
    end else begin
      ext_q_r <= i_ext_int;
    end
  end

  // Requests stay latched while the stack is full; set wins
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pend_r <= 3'h0;
    end else begin
      pend_r <= (pend_r & ~ack_vec) | ev;  // RULE21
    end
  end

  // Acknowledge only when no other pc source is active
  assign ack_ok = (st_r == S_IDLE) & ~ph_r & (sp_r != STK_FULL);  // RULE21

  always_comb begin
    ack_vec = 3'h0;
    vec_sel = RST_VEC;
    if (ack_ok & pend_r[P_EXT]) begin
      ack_vec[P_EXT] = 1'b1;
      vec_sel        = EXT_VEC;  // RULE2
    end else if (ack_ok & pend_r[P_TMR]) begin
      ack_vec[P_TMR] = 1'b1;
      vec_sel        = TMR_VEC;  // RULE4
    end else if (ack_ok & pend_r[P_ADC]) begin
      ack_vec[P_ADC] = 1'b1;
      vec_sel        = ADC_VEC;  // RULE5 RULE22
    end
  end

  // ==========================================================
  // Program counter and return stack
  assign sp_dec = sp_r - 2'h1;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pc_r <= RST_VEC;  // RULE1
      sp_r <= 2'h0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk_r[i] <= 10'h000;
      end
    end else if (|ack_vec) begin
      stk_r[sp_r[0]] <= pc_r;
      sp_r           <= sp_r + 2'h1;
      pc_r           <= vec_sel;
    end else if (cmd_go & (cmd_op == OP_RET) & (sp_r != 2'h0)) begin
      pc_r <= stk_r[sp_dec[0]];
      sp_r <= sp_dec;
    end else if (cmd_go & (cmd_op == OP_STEP)) begin
      pc_r <= pc_r + 10'h001;
    end else if (wr_en & (wr_a == A_PCL)) begin
      pc_r <= {pc_r[9:8], wr_d};
    end
  end

  // ==========================================================
  // Checks
  reset_vector_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE1
    !$past(i_rst_n) |-> pc_r == RST_VEC) else $error("pc not at reset vector");
  ext_vector_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE2
    ack_vec[P_EXT] |=> pc_r == EXT_VEC && sp_r == $past(sp_r) + 2'h1)
    else $error("external vector not taken");
  fall_edge_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE3
    system_control_reg_1_r[C_EDGE_LSB +: 2] == EDGE_FALL
    && system_control_reg_1_r[C_EXT_EN] && ext_q_r && !i_ext_int
    |=> pend_r[P_EXT] || pc_r == EXT_VEC) else $error("falling edge lost");
  tmr_vector_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE4
    ack_vec[P_TMR] |=> pc_r == TMR_VEC) else $error("timer vector not taken");
  adc_vector_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE5
    ack_vec[P_ADC] |=> pc_r == ADC_VEC) else $error("converter vector not taken");
  // Word fetched must be the one in the final page
  last_page_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE10
    st_r == S_FETCH && op_r == OP_TABRDL |=> tw_r == pm_mem[{LAST_PAGE, $past(tblp_r)}])
    else $error("last page address wrong");
  table_two_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE11
    st_r == S_FETCH |=> st_r == S_WRITE ##1 st_r == S_IDLE)
    else $error("table read length wrong");
  table_high_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE8
    st_r == S_WRITE |=> table_high_byte_r == {2'h0, $past(tw_hi)})
    else $error("table high wrong");
  high_locked_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE12
    wr_en && wr_a == A_TABLE_HIGH_BYTE && st_r != S_WRITE |=> $stable(table_high_byte_r))
    else $error("table high changed by write");
  stack_full_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE21
    sp_r == STK_FULL |-> ack_vec == 3'h0) else $error("ack with full stack");
  unused_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)  // RULE18
    done && !wr_r && dm_hit && eff_a(a_dm) >= GP_END |=> o_hrdata == 32'h0000_0000)
    else $error("unused address not zero");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vtr_pkg::*;
  // ==========================================================
  // Bench signals
  logic        i_mclk;
  logic        i_rst_n;
  logic        i_hsel;
  logic [31:0] i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic        i_ext_int;
  logic        i_tmr_ovf;
  logic        i_adc_done;
  logic [9:0]  o_pc;
  int          fails;
  int          check_count;

  // Single slave, so its ready is the bus ready
  vtr_top i_vtr_top (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (o_hreadyout),
    .o_hrdata    (o_hrdata),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .i_ext_int   (i_ext_int),
    .i_tmr_ovf   (i_tmr_ovf),
    .i_adc_done  (i_adc_done),
    .o_pc        (o_pc)
  );

  // 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // Checking and closing
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ==========================================================
  // AHB-Lite master: ready is sampled as it stood before each edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_hsel   <= 1'b1;
    i_haddr  <= {20'h0_0000, a};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    i_htrans <= 2'h0;
    i_hsel   <= 1'b0;
    i_hwdata <= wd;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 100);
    rd = o_hrdata;
    chk("hresp", {31'h0, o_hresp}, 32'h0000_0000);
    if (n >= 100) begin
      chk("hready", {31'h0, o_hreadyout}, 32'h0000_0001);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(nm, x, e);
  endtask

  // Data memory byte a sits at word 0x400 + 4a
  function automatic logic [11:0] dm(input logic [7:0] a);
    return 12'h400 + {2'h0, a, 2'h0};
  endfunction

  task automatic cmd(input logic [2:0] op, input logic [2:0] bt, input logic [7:0] m);
    wr(OFS_CMD, {13'h0, op, 5'h00, bt, m});
  endtask

  // Poll the program counter, bounded
  task automatic wait_pc(input logic [9:0] e);
    logic [31:0] x;
    int          n;
    n = 0;
    do begin
      bus(1'b0, OFS_PC, 32'h0000_0000, x);
      n++;
    end while (x[9:0] !== e && n < 20);
    chk("pc", x, {22'h0, e});
    chk("pc port", {22'h0, o_pc}, {22'h0, e});
  endtask

  task automatic pulse(input logic t, input logic d);
    @(posedge i_mclk);
    i_tmr_ovf  <= t;
    i_adc_done <= d;
    @(posedge i_mclk);
    i_tmr_ovf  <= 1'b0;
    i_adc_done <= 1'b0;
  endtask

  // Drive the pin level; expect a vector or nothing
  task automatic ext_try(input logic v, input logic hit);
    @(posedge i_mclk);
    i_ext_int <= v;
    if (hit) begin
      wait_pc(EXT_VEC);
      cmd(OP_RET, 3'h0, 8'h00);
      wait_pc(10'h000);
    end else begin
      repeat (6) @(posedge i_mclk);
      rdchk("pc idle", OFS_PC, 32'h0000_0000);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] un [7];
    logic [7:0] acc;
    un = '{8'h02, 8'h05, 8'h0A, 8'h0F, 8'h1F, 8'h40, 8'hFF};
    fails = 0;
    check_count = 0;
    i_rst_n = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h0000_0000;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0000_0000;
    i_ext_int = 1'b0;
    i_tmr_ovf = 1'b0;
    i_adc_done = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rdchk("pc reset", OFS_PC, 32'h0000_0000);
    rdchk("ctrl reset", dm(A_SYSTEM_CONTROL_REG_1), {24'h0, CONTROL_RST});
    // Unused and reserved bytes ignore writes and read zero
    foreach (un[i]) begin
      wr(dm(un[i]), 32'h0000_00FF);
      rdchk("unused", dm(un[i]), 32'h0000_0000);
    end
    for (int a = 8'h20; a < 8'h40; a++) begin
      wr(dm(8'(a)), {24'h0, 8'(a) ^ 8'h5A});
    end
    for (int a = 8'h20; a < 8'h40; a++) begin
      rdchk("ram", dm(8'(a)), {24'h0, 8'(a) ^ 8'h5A});
    end
    wr(dm(A_MP0), 32'h0000_0023);
    wr(dm(A_IAR0), 32'h0000_0077);
    rdchk("ind direct", dm(8'h23), 32'h0000_0077);
    rdchk("ind slot", dm(A_IAR0), 32'h0000_0077);
    wr(dm(A_MP0), 32'h0000_0000);
    rdchk("ind self", dm(A_IAR0), 32'h0000_0000);
    // Bit set walks every bit, then one clear
    wr(dm(8'h26), 32'h0000_0000);
    acc = 8'h00;
    for (int b = 0; b < 8; b++) begin
      cmd(OP_BSET, 3'(b), 8'h26);
      acc[b] = 1'b1;
      rdchk("bit set", dm(8'h26), {24'h0, acc});
    end
    cmd(OP_BCLR, 3'h5, 8'h26);
    rdchk("bit clr", dm(8'h26), 32'h0000_00DF);
    cmd(OP_BSET, 3'h7, A_TABLE_HIGH_BYTE);
    wr(dm(A_TABLE_HIGH_BYTE), 32'h0000_00FF);
    rdchk("tbl high ro", dm(A_TABLE_HIGH_BYTE), 32'h0000_0000);
    wr(dm(A_SEQ), 32'h0000_00FF);
    rdchk("status ro", dm(A_SEQ), 32'h0000_0000);
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_00FF);
    rdchk("ctrl mask", dm(A_SYSTEM_CONTROL_REG_1), {24'h0, CONTROL_MASK});
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0000);
    // Every edge mode, a rise then a fall
    for (int m = 0; m < 4; m++) begin
      wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0004 | m);
      ext_try(1'b1, m != 0);
      ext_try(1'b0, m != 1);
    end
    // Disabled sources are dropped
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0003);
    ext_try(1'b1, 1'b0);
    ext_try(1'b0, 1'b0);
    pulse(1'b1, 1'b1);
    repeat (6) @(posedge i_mclk);
    rdchk("pc off", OFS_PC, 32'h0000_0000);
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0008);
    pulse(1'b1, 1'b0);
    wait_pc(TMR_VEC);
    cmd(OP_RET, 3'h0, 8'h00);
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0010);
    pulse(1'b0, 1'b1);
    wait_pc(ADC_VEC);
    cmd(OP_RET, 3'h0, 8'h00);
    // Both at once: timer wins, so it returns to the timer vector
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0018);
    pulse(1'b1, 1'b1);
    wait_pc(ADC_VEC);
    cmd(OP_RET, 3'h0, 8'h00);
    wait_pc(TMR_VEC);
    cmd(OP_RET, 3'h0, 8'h00);
    wait_pc(10'h000);
    // Full stack holds the external request until a return
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_001D);
    pulse(1'b1, 1'b0);
    wait_pc(TMR_VEC);
    pulse(1'b0, 1'b1);
    wait_pc(ADC_VEC);
    // Rising pin edge while no stack level is free; pc sits at a vector
    @(posedge i_mclk);
    i_ext_int <= 1'b1;
    repeat (6) @(posedge i_mclk);
    rdchk("pc held", OFS_PC, {22'h0, ADC_VEC});
    rdchk("pend full", OFS_CMD, 32'h0000_0006);
    rdchk("status", dm(A_SEQ), 32'h0000_0006);
    cmd(OP_RET, 3'h0, 8'h00);
    wait_pc(EXT_VEC);
    rdchk("pend done", OFS_CMD, 32'h0000_0002);
    cmd(OP_RET, 3'h0, 8'h00);
    wait_pc(TMR_VEC);
    cmd(OP_RET, 3'h0, 8'h00);
    wait_pc(10'h000);
    wr(dm(A_SYSTEM_CONTROL_REG_1), 32'h0000_0000);
    // Table words in pages 0, 2 and 3
    wr(OFS_PMA, 32'h0000_0305);
    wr(OFS_PMD, 32'h0000_3FA5);
    wr(OFS_PMA, 32'h0000_0005);
    wr(OFS_PMD, 32'h0000_1234);
    wr(OFS_PMA, 32'h0000_0205);
    wr(OFS_PMD, 32'h0000_0ABC);
    wr(OFS_PMA, 32'h0000_0305);
    rdchk("pm", OFS_PMD, 32'h0000_3FA5);
    wr(dm(A_TBLP), 32'h0000_0005);
    cmd(OP_TABRDL, 3'h0, 8'h30);
    rdchk("tab low", dm(8'h30), 32'h0000_00A5);
    rdchk("tab high", dm(A_TABLE_HIGH_BYTE), 32'h0000_003F);
    cmd(OP_TABLE_READ_CURRENT_PAGE, 3'h0, 8'h31);
    rdchk("cur low", dm(8'h31), 32'h0000_0034);
    rdchk("cur high", dm(A_TABLE_HIGH_BYTE), 32'h0000_0012);
    // Walk the counter into page 2 for a non-zero upper field
    for (int s = 0; s < 512; s++) begin
      cmd(OP_STEP, 3'h0, 8'h00);
    end
    rdchk("pc step", OFS_PC, 32'h0000_0200);
    cmd(OP_TABLE_READ_CURRENT_PAGE, 3'h0, 8'h32);
    rdchk("pg2 low", dm(8'h32), 32'h0000_00BC);
    rdchk("pg2 high", dm(A_TABLE_HIGH_BYTE), 32'h0000_000A);
    cmd(OP_TABRDL, 3'h0, 8'h33);
    rdchk("last low", dm(8'h33), 32'h0000_00A5);
    rdchk("tbl ptr", dm(A_TBLP), 32'h0000_0005);
    // Low byte jump stays in the current page
    wr(dm(A_PCL), 32'h0000_0077);
    rdchk("pcl jump", OFS_PC, 32'h0000_0277);
    rdchk("pcl", dm(A_PCL), 32'h0000_0077);
    end_of_test();
  end
endmodule
`default_nettype wire
